// File: rtl/ptb_time_base.v
// pwm time base: 16-bit counter, period compare, modes, special event postscaler
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defs.vh"

module ptb_time_base #(
   parameter CNT_W = 16
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire [3:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   output reg        pwm_out,
   output reg        event_trigger,
   output reg        count_direction_flag,
   output reg        override_sync_select
);

   // -----------------------------------------------------------------
   // software registers
   // -----------------------------------------------------------------
   reg             time_base_run_enable_r;
   reg  [1:0]      input_prescale_select_r;
   reg  [1:0]      mode_r;
   reg  [7:0]      pwm_control_one_r;
   reg  [CNT_W-1:0] time_base_count_r;
   reg  [CNT_W-1:0] period_buf_r;
   reg  [CNT_W-1:0] time_base_period_r;   // active period
   reg  [CNT_W-1:0] duty_buf_r;
   reg  [CNT_W-1:0] duty_act_r;
   reg             first_half_r;
   reg  [3:0]      post_cnt_r;

   wire            tick;
   wire            wr_ctrl0 = wr && (addr == `PTB_ADDR_CTRL0);
   wire            wr_ctrl1 = wr && (addr == `PTB_ADDR_CTRL1);
   wire            wr_cnt_lo = wr && (addr == `PTB_ADDR_COUNT_LO);
   wire            wr_cnt_hi = wr && (addr == `PTB_ADDR_COUNT_HI);
   wire            wr_cnt = wr_cnt_lo || wr_cnt_hi;
   wire            updn = mode_r[1];
   wire            match = (time_base_count_r == time_base_period_r);
   wire            at_zero = (time_base_count_r == {CNT_W{1'b0}});
   wire            buffer_update_disable = pwm_control_one_r[`PTB_P1_BUFFER_UPDATE_DISABLE];
   wire            tdir = pwm_control_one_r[`PTB_P1_TDIR];
   wire [3:0]      post_sel = pwm_control_one_r[`PTB_P1_POST_HI:`PTB_P1_POST_LO];
   reg             period_end;

   // -----------------------------------------------------------------
   // prescaler, cleared by counter or control writes
   // -----------------------------------------------------------------
   ptb_prescaler u_pre (
      .clk   (clk),
      .rst_n (rst_n),
      .clr   (wr_cnt || wr_ctrl0 || wr_ctrl1),
      .sel   (input_prescale_select_r),
      .tick  (tick)
   );

   // -----------------------------------------------------------------
   // control registers
   // -----------------------------------------------------------------
   // single-shot clears run enable in hardware; a software write in the same cycle wins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         time_base_run_enable_r  <= 1'b0;
         input_prescale_select_r <= 2'b00;
         mode_r                  <= `PTB_MODE_FREE;
         pwm_control_one_r       <= `PTB_RST_BYTE;
      end else begin
         if (wr_ctrl0) begin
            time_base_run_enable_r  <= wdata[`PTB_C0_RUN];
            input_prescale_select_r <= wdata[`PTB_C0_PRE_HI:`PTB_C0_PRE_LO];
            mode_r                  <= wdata[`PTB_C0_MODE_HI:`PTB_C0_MODE_LO];
         end else if (tick && time_base_run_enable_r && (mode_r == `PTB_MODE_SINGLE) && match) begin
            time_base_run_enable_r <= 1'b0;
         end
         if (wr && (addr == `PTB_ADDR_PWMCTL1))
            pwm_control_one_r <= wdata & `PTB_P1_RESERVED;
      end
   end

   // -----------------------------------------------------------------
   // counter, direction and first-half hold
   // -----------------------------------------------------------------
   // control writes never touch the count; the prescaler restarts, and on control one the postscaler count clears too
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         time_base_count_r    <= `PTB_RST_WORD;
         count_direction_flag <= 1'b0;
         first_half_r         <= 1'b1;
      end else if (wr_cnt) begin
         if (wr_cnt_lo)
            time_base_count_r[7:0] <= wdata;
         else
            time_base_count_r[15:8] <= wdata;
      end else if (!time_base_run_enable_r) begin
         count_direction_flag <= 1'b0;
         first_half_r         <= 1'b1;
      end else if (tick) begin
         if (!updn) begin
            count_direction_flag <= 1'b0;
            if (match)
               time_base_count_r <= {CNT_W{1'b0}};
            else
               time_base_count_r <= time_base_count_r + 16'd1;
         end else if (!count_direction_flag) begin
            if (match) begin
               count_direction_flag <= 1'b1;
               first_half_r         <= 1'b0;
               time_base_count_r    <= time_base_count_r - 16'd1;
            end else begin
               time_base_count_r <= time_base_count_r + 16'd1;
            end
         end else begin
            if (at_zero) begin
               count_direction_flag <= 1'b0;
               time_base_count_r    <= time_base_count_r + 16'd1;
            end else begin
               time_base_count_r <= time_base_count_r - 16'd1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // buffers and copy to active at period boundary
   // -----------------------------------------------------------------
   always @* begin
      if (updn)
         period_end = count_direction_flag && at_zero;
      else
         period_end = match;
   end

   // while running, copying only at the boundary keeps a period from being cut short mid-cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         period_buf_r       <= `PTB_RST_WORD;
         duty_buf_r         <= `PTB_RST_WORD;
         time_base_period_r <= `PTB_RST_WORD;
         duty_act_r         <= `PTB_RST_WORD;
      end else begin
         if (wr && addr == `PTB_ADDR_PERIOD_LO) period_buf_r[7:0]  <= wdata;
         if (wr && addr == `PTB_ADDR_PERIOD_HI) period_buf_r[15:8] <= wdata;
         if (wr && addr == `PTB_ADDR_DUTY_LO)   duty_buf_r[7:0]    <= wdata;
         if (wr && addr == `PTB_ADDR_DUTY_HI)   duty_buf_r[15:8]   <= wdata;
         if (!buffer_update_disable && (!time_base_run_enable_r || (tick && period_end))) begin
            time_base_period_r <= period_buf_r;
            duty_act_r         <= duty_buf_r;
         end
      end
   end

   // -----------------------------------------------------------------
   // pwm output, special event trigger with postscaler
   // -----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_out              <= 1'b0;
         event_trigger        <= 1'b0;
         post_cnt_r           <= 4'h0;
         override_sync_select <= 1'b0;
      end else begin
         override_sync_select <= pwm_control_one_r[`PTB_P1_OVERRIDE_SYNC_SELECT];
         pwm_out <= time_base_run_enable_r && !(updn && first_half_r)
                    && (time_base_count_r < duty_act_r);
         event_trigger <= 1'b0;
         if (wr_ctrl1 || (wr && addr == `PTB_ADDR_PWMCTL1)) begin
            post_cnt_r <= 4'h0;
         end else if (tick && time_base_run_enable_r && match
                      && (count_direction_flag == tdir)) begin
            if (post_cnt_r >= post_sel) begin
               post_cnt_r    <= 4'h0;
               event_trigger <= 1'b1;
            end else begin
               post_cnt_r <= post_cnt_r + 4'h1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // read port: data stand in the cycle after the strobe
   // -----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= `PTB_RST_BYTE;
      end else if (rd) begin
         case (addr)
            `PTB_ADDR_CTRL0:     rdata <= {time_base_run_enable_r, 3'b000, input_prescale_select_r, mode_r};
            `PTB_ADDR_CTRL1:     rdata <= {count_direction_flag, 7'b000_0000};
            `PTB_ADDR_COUNT_LO:  rdata <= time_base_count_r[7:0];
            `PTB_ADDR_COUNT_HI:  rdata <= time_base_count_r[15:8];
            `PTB_ADDR_PERIOD_LO: rdata <= period_buf_r[7:0];
            `PTB_ADDR_PERIOD_HI: rdata <= period_buf_r[15:8];
            `PTB_ADDR_PWMCTL1:   rdata <= pwm_control_one_r;
            `PTB_ADDR_DUTY_LO:   rdata <= duty_buf_r[7:0];
            `PTB_ADDR_DUTY_HI:   rdata <= duty_buf_r[15:8];
            default:             rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// File: rtl/ptb_defs.vh
// constants for the pwm time base: register offsets, fields, reset values, timing
`ifndef PTB_DEFS_VH
`define PTB_DEFS_VH

// -----------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// -----------------------------------------------------------------
`define PTB_ADDR_CTRL0      4'h0
`define PTB_ADDR_CTRL1      4'h1
`define PTB_ADDR_COUNT_LO   4'h2
`define PTB_ADDR_COUNT_HI   4'h3
`define PTB_ADDR_PERIOD_LO  4'h4
`define PTB_ADDR_PERIOD_HI  4'h5
`define PTB_ADDR_PWMCTL1    4'h6
`define PTB_ADDR_DUTY_LO    4'h7
`define PTB_ADDR_DUTY_HI    4'h8

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
// control zero: [7] run enable, [3:2] input prescale select, [1:0] mode
`define PTB_C0_RUN          7
`define PTB_C0_PRE_HI       3
`define PTB_C0_PRE_LO       2
`define PTB_C0_MODE_HI      1
`define PTB_C0_MODE_LO      0
// control one: [7] count direction flag (read only)
`define PTB_C1_DIR          7
// pwm control one: [7:4] postscale, [3] trigger dir, [2] zero, [1] update disable, [0] override sync
`define PTB_P1_POST_HI      7
`define PTB_P1_POST_LO      4
`define PTB_P1_TDIR         3
`define PTB_P1_BUFFER_UPDATE_DISABLE         1
`define PTB_P1_OVERRIDE_SYNC_SELECT        0

// -----------------------------------------------------------------
// modes and reset values
// -----------------------------------------------------------------
`define PTB_MODE_FREE       2'b00
`define PTB_MODE_SINGLE     2'b01
`define PTB_MODE_UPDN       2'b10
`define PTB_MODE_UPDN_INT   2'b11
`define PTB_RST_BYTE        8'h00
`define PTB_RST_WORD        16'h0000
`define PTB_P1_RESERVED     8'hFB

// -----------------------------------------------------------------
// timing: instruction clock is the oscillator divided by four
// -----------------------------------------------------------------
`define PTB_OSC_DIV         4
`define PTB_PRE_W           6

`endif

// File: rtl/ptb_prescaler.v
// prescaler that turns the instruction tick into the time base input tick
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defs.vh"

module ptb_prescaler (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       clr,
   input  wire [1:0] sel,
   output reg        tick
);

   // -----------------------------------------------------------------
   // oscillator divided by four, then 1:1/4/16/64
   // -----------------------------------------------------------------
   reg  [1:0]              osc_cnt_r;
   reg  [`PTB_PRE_W-1:0]   pre_cnt_r;
   wire                    inst_tick;
   reg                     pre_done;

   assign inst_tick = (osc_cnt_r == 2'd3);

   // terminal count chosen by the select field
   always @* begin
      case (sel)
         2'b00:   pre_done = 1'b1;
         2'b01:   pre_done = (pre_cnt_r[1:0] == 2'b11);
         2'b10:   pre_done = (pre_cnt_r[3:0] == 4'hF);
         default: pre_done = (pre_cnt_r == 6'h3F);
      endcase
   end

   // both counters restart on clr so the first tick after a write is a full period
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_cnt_r <= 2'd0;
         pre_cnt_r <= {`PTB_PRE_W{1'b0}};
         tick      <= 1'b0;
      end else if (clr) begin
         osc_cnt_r <= 2'd0;
         pre_cnt_r <= {`PTB_PRE_W{1'b0}};
         tick      <= 1'b0;
      end else begin
         osc_cnt_r <= osc_cnt_r + 2'd1;
         tick      <= 1'b0;
         if (inst_tick) begin
            if (pre_done) begin
               pre_cnt_r <= {`PTB_PRE_W{1'b0}};
               tick      <= 1'b1;
            end else begin
               pre_cnt_r <= pre_cnt_r + 6'd1;
            end
         end
      end
   end

endmodule
`default_nettype wire

// File: testbench/ptb_time_base_sva.sv
// assertion checker for the pwm time base register port and outputs
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defs.vh"
module ptb_tb_sva #(
   parameter CNT_W = 16
) (
   input wire       clk,
   input wire       rst_n,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   input wire       pwm_out,
   input wire       event_trigger,
   input wire       count_direction_flag,
   input wire       override_sync_select
);
   // -----------------------------------------------------------
   // properties, all on the one clock
   // -----------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // outputs must come out of reset quiet
   reset_quiet_a: assert property ($rose(rst_n) |-> !pwm_out && !event_trigger && !count_direction_flag && rdata == 8'h00)
      else $error("outputs busy after reset");
   // read data stands only in the cycle after a read
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not zero");
   dir_read_a: assert property (
      rd && addr == `PTB_ADDR_CTRL1 |=> rdata == {$past(count_direction_flag), 7'h00}) else $error("direction read");
   unmapped_read_a: assert property (rd && addr > `PTB_ADDR_DUTY_HI |=> rdata == 8'h00) else $error("unmapped read");
   p1_readback_a: assert property (
      wr && addr == `PTB_ADDR_PWMCTL1 ##1 rd && addr == `PTB_ADDR_PWMCTL1 |=> rdata == ($past(wdata, 2) & 8'hFB))
      else $error("control one readback");
   period_read_a: assert property (
      wr && addr == `PTB_ADDR_PERIOD_HI ##1 rd && addr == `PTB_ADDR_PERIOD_HI |=> rdata == $past(wdata, 2))
      else $error("period readback");
   override_sync_select_copy_a: assert property (wr && addr == `PTB_ADDR_PWMCTL1 |=> ##1 override_sync_select == $past(wdata[0], 2))
      else $error("override sync copy");
   // a trigger is one pulse; a tick never comes sooner than four clocks
   trig_pulse_a: assert property (event_trigger |=> !event_trigger [*3]) else $error("trigger too long");
   cover_trig_c: cover property (event_trigger);
   cover_down_c: cover property ($rose(count_direction_flag));
   cover_pwm_c: cover property ($rose(pwm_out));
endmodule
bind ptb_time_base ptb_tb_sva #(.CNT_W(CNT_W)) i_sva (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .pwm_out(pwm_out), .event_trigger(event_trigger),
   .count_direction_flag(count_direction_flag), .override_sync_select(override_sync_select));
`default_nettype wire

// File: testbench/ptb_time_base_test.sv
// self-checking bench for the pwm time base
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defs.vh"
module ptb_time_base_test;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   wire  [7:0] rdata;
   wire        pwm_out;
   wire        event_trigger;
   wire        count_direction_flag;
   wire        override_sync_select;
   int         n_mismatch = 0;
   int         n_tests = 0;
   logic [7:0] rv;

   ptb_time_base i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .pwm_out(pwm_out), .event_trigger(event_trigger), .count_direction_flag(count_direction_flag),
      .override_sync_select(override_sync_select));

   // 50 MHz clock
   always #10 clk = ~clk;

   // -----------------------------------------------------------
   // bus and compare helpers
   // -----------------------------------------------------------
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // strobes are set once per call, so no signal is assigned twice in one step
   task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask
   // read data stand only in the cycle after the strobe, so take them mid-cycle
   task automatic rreg(input logic [3:0] a);
      bus(1'b0, 1'b1, a, 8'h00);
      rd <= 1'b0;
      addr <= 4'h0;
      @(negedge clk);
      rv = rdata;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
   endtask
   // ticks land 4*div*k+1 edges after the start write; stops sit 2 edges clear of them, the t_updn stop 1 edge before one
   task automatic start(input logic [15:0] cnt, input logic [15:0] per, input logic [7:0] c0);
      wreg(`PTB_ADDR_PERIOD_LO, per[7:0]);
      wreg(`PTB_ADDR_PERIOD_HI, per[15:8]);
      wreg(`PTB_ADDR_COUNT_LO, cnt[7:0]);
      wreg(`PTB_ADDR_COUNT_HI, cnt[15:8]);
      wreg(`PTB_ADDR_CTRL0, c0);
   endtask
   task automatic stop_read(input int g, input logic [7:0] c0, input logic [15:0] exp);
      idle(g - 1);
      wreg(`PTB_ADDR_CTRL0, c0 & 8'h7F);
      rreg(`PTB_ADDR_COUNT_LO);
      check("count low", exp[7:0], rv);
      rreg(`PTB_ADDR_COUNT_HI);
      check("count high", exp[15:8], rv);
   endtask

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic t_regs;
      for (int a = 0; a < 16; a++) begin
         rreg(a[3:0]);
         check("reset value", 8'h00, rv);
      end
      wreg(`PTB_ADDR_PWMCTL1, 8'hFF);
      rreg(`PTB_ADDR_PWMCTL1);
      check("pwm control one", 8'hFB, rv);
      check("override sync", 8'h01, {7'h00, override_sync_select});
      wreg(`PTB_ADDR_PWMCTL1, 8'h00);
      wreg(`PTB_ADDR_PERIOD_HI, 8'hA5);
      rreg(`PTB_ADDR_PERIOD_HI);
      check("period high", 8'hA5, rv);
      wreg(4'hF, 8'h3C);
      rreg(4'hF);
      check("unmapped", 8'h00, rv);
   endtask
   // free run at period 1: ten matches in twenty ticks
   task automatic t_event(input logic [7:0] p, input int n_exp);
      int n;
      n = 0;
      wreg(`PTB_ADDR_PWMCTL1, p);
      start(16'h0000, 16'h0001, 8'h80);
      for (int i = 0; i < 92; i++) begin
         bus(i == 82, 1'b0, `PTB_ADDR_CTRL0, 8'h00);
         n += event_trigger;
      end
      check("trigger count", n_exp[7:0], n[7:0]);
   endtask
   // up/down at period 3: five ticks give 1,2,3,2,1
   task automatic t_updn;
      wreg(`PTB_ADDR_PWMCTL1, 8'h00);
      wreg(`PTB_ADDR_DUTY_LO, 8'h02);
      wreg(`PTB_ADDR_DUTY_HI, 8'h00);
      start(16'h0000, 16'h0003, {4'h8, 2'b00, `PTB_MODE_UPDN});
      for (int i = 0; i < 21; i++) begin
         bus(1'b0, 1'b0, 4'h0, 8'h00);
         if (count_direction_flag === 1'b0) check("pwm first half", 8'h00, {7'h00, pwm_out});
      end
      rreg(`PTB_ADDR_CTRL1);
      check("direction read", 8'h80, rv);
      stop_read(1, {4'h8, 2'b00, `PTB_MODE_UPDN}, 16'h0001);
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      start(16'h00FE, 16'h0100, 8'h80);
      stop_read(23, 8'h80, 16'h0002);
      for (int s = 0; s < 4; s++) begin
         start(16'h0000, 16'hFFFF, {4'h8, s[1:0], `PTB_MODE_FREE});
         stop_read(8 * (1 << (2 * s)) + 3, 8'h80, 16'h0002);
      end
      start(16'h0000, 16'h0002, {4'h8, 2'b00, `PTB_MODE_SINGLE});
      idle(40);
      rreg(`PTB_ADDR_CTRL0);
      check("single shot control", 8'h01, rv & 8'h8F);
      rreg(`PTB_ADDR_COUNT_LO);
      check("single shot count", 8'h00, rv);
      t_event(8'h00, 10);
      t_event(8'h10, 5);
      t_event(8'h08, 0);
      wreg(`PTB_ADDR_PERIOD_LO, 8'h03);
      wreg(`PTB_ADDR_PERIOD_HI, 8'h00);
      wreg(`PTB_ADDR_PWMCTL1, 8'h02);
      start(16'h0000, 16'hFFFF, 8'h80);
      stop_read(23, 8'h80, 16'h0001);
      t_updn();
      finish_test();
   end

   // watchdog: the sequence needs about 1200 cycles
   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end

   task automatic finish_test;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
endmodule
`default_nettype wire
